// >>> hw/lfd_pkg.sv
// lfd_pkg: constants, gamma table and carrier types of the led fade dimming controller
// assumes a 50 MHz system clock and a 32-bit apb register bus
package lfd_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_NS = 20;
  // debounce interval in ns and its cycle count
  localparam int DEBOUNCE_NS = 37_000_000;
  localparam int DEB_CYC = DEBOUNCE_NS / CLK_NS;
  localparam int DEB_W = 21;
  // internal pwm: 220 hz carrier, duty on a scale of 1000
  localparam int PWM_HZ = 220;
  localparam int DUTY_SCALE = 1000;
  localparam int PWM_STEP_CYC = CLK_HZ / (PWM_HZ * DUTY_SCALE);
  // fade time unit 2.5 us per programming unit
  localparam int UNIT_NS = 2500;
  localparam int UNIT_CYC = UNIT_NS / CLK_NS;
  // cancelled fade completes in about 70 us over all steps
  localparam int FAST_NS = 70_000;
  localparam int STEPS = 63;
  localparam int FAST_STEP_CYC = FAST_NS / (CLK_NS * STEPS);
  localparam logic [5:0] LVL_MAX = 6'h3E;
  localparam logic [5:0] STEP_INC = 6'h3F;
  // register map (byte addresses)
  localparam logic [7:0] ADDR_FADE_IN = 8'h00;
  localparam logic [7:0] ADDR_FADE_OUT = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  // values after reset
  localparam logic [19:0] FADE_IN_RST = 20'h1E848;
  localparam logic [19:0] FADE_OUT_RST = 20'h1E848;
  // duty per gamma index
  localparam logic [9:0] GAMMA [0:62] = '{
    10'd0, 10'd2, 10'd4, 10'd6, 10'd8, 10'd10, 10'd12, 10'd16,
    10'd20, 10'd24, 10'd28, 10'd32, 10'd36, 10'd42, 10'd48, 10'd54,
    10'd60, 10'd66, 10'd72, 10'd80, 10'd88, 10'd96, 10'd104, 10'd112,
    10'd120, 10'd130, 10'd140, 10'd150, 10'd160, 10'd170, 10'd180, 10'd194,
    10'd208, 10'd222, 10'd236, 10'd250, 10'd264, 10'd282, 10'd300, 10'd318,
    10'd336, 10'd354, 10'd372, 10'd394, 10'd416, 10'd438, 10'd460, 10'd482,
    10'd504, 10'd534, 10'd564, 10'd594, 10'd624, 10'd654, 10'd684, 10'd722,
    10'd760, 10'd798, 10'd836, 10'd874, 10'd914, 10'd956, 10'd1000};

  typedef enum logic {LFD_AUTO_FADE, LFD_DIRECT} lfd_mode_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } lfd_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } lfd_apb_rsp_t;

  typedef struct packed {
    logic [1:0] dim_sy;
    logic [1:0] mode_sy;
    logic [1:0] pol_sy;
    logic [1:0] uvl_sy;
    logic [1:0] uvh_sy;
    logic [1:0] sw_m1;
    logic [1:0] sw_s;
    lfd_mode_t mode;
    logic lit;
    logic owner;
    logic deb_lvl;
    logic [DEB_W-1:0] deb_cnt;
    logic [5:0] level;
    logic [26:0] acc;
    logic [5:0] fast_cnt;
    logic [7:0] pwm_pre;
    logic [9:0] pwm_cnt;
    logic uv_off;
    logic [1:0] out;
    logic [19:0] fade_in;
    logic [19:0] fade_out;
    lfd_apb_rsp_t rsp;
  } lfd_state_t;
endpackage

// >>> hw/lfd_top.sv
// lfd_top: shared dimming input, auto fade ramp, internal pwm and uv lockout for both main channels
// assumes reset_i is the power-on / below-lower-threshold condition and pins are asynchronous
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module lfd_top #(
  parameter int DEB_CYC = lfd_pkg::DEB_CYC
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire lfd_pkg::lfd_apb_req_t apb_i,
  output lfd_pkg::lfd_apb_rsp_t apb_o,
  input wire logic dim_i,
  input wire logic dimming_source_select_i,
  input wire logic polarity_select_i,
  input wire logic [1:0] channel_switch_inputs_i,
  input wire logic uv_below_4v5_i,
  input wire logic uv_above_4v6_i,
  output logic [1:0] main_led_outputs_o
);
  localparam int DEB_W = lfd_pkg::DEB_W;
  lfd_pkg::lfd_state_t st_ff;
  lfd_pkg::lfd_state_t nxt_st;

  function automatic logic [1:0] sync2(input logic [1:0] s, input logic pin);
    sync2 = {s[0], pin};
  endfunction

  logic dim_s;
  logic act_now;
  logic deb_evt;
  logic deb_act;
  logic ramping;
  logic [19:0] set_val;
  logic step;
  logic [26:0] acc_sum;
  logic [26:0] ramp_thr;
  logic wr;

  assign dim_s = st_ff.dim_sy[1];
  assign act_now = dim_s ~^ st_ff.pol_sy[1];
  assign deb_act = st_ff.deb_lvl ~^ st_ff.pol_sy[1];
  assign set_val = st_ff.lit ? st_ff.fade_in : st_ff.fade_out;
  // 63 added every cycle against setting times cycles per unit: one step per sixty-third of the ramp
  assign acc_sum = st_ff.acc + 27'(lfd_pkg::STEP_INC);
  assign ramp_thr = 27'(set_val) * 27'(lfd_pkg::UNIT_CYC);
  assign ramping = st_ff.lit ? (st_ff.level != lfd_pkg::LVL_MAX) : (st_ff.level != 6'h00);
  assign deb_evt = (st_ff.mode == lfd_pkg::LFD_AUTO_FADE) && (dim_s != st_ff.deb_lvl) &&
                   (st_ff.deb_cnt == DEB_W'(DEB_CYC - 1));
  assign wr = apb_i.psel && apb_i.penable && apb_i.pwrite && st_ff.rsp.pready;

  always_comb begin
    nxt_st = st_ff;
    step = 1'b0;
    // pin synchronisers
    nxt_st.dim_sy = sync2(st_ff.dim_sy, dim_i);
    nxt_st.mode_sy = sync2(st_ff.mode_sy, dimming_source_select_i);
    nxt_st.pol_sy = sync2(st_ff.pol_sy, polarity_select_i);
    nxt_st.uvl_sy = sync2(st_ff.uvl_sy, uv_below_4v5_i);
    nxt_st.uvh_sy = sync2(st_ff.uvh_sy, uv_above_4v6_i);
    nxt_st.sw_m1 = channel_switch_inputs_i;
    nxt_st.sw_s = st_ff.sw_m1;
    nxt_st.mode = st_ff.mode_sy[1] ? lfd_pkg::LFD_DIRECT : lfd_pkg::LFD_AUTO_FADE;
    // debounce, same count for both edges
    if (dim_s == st_ff.deb_lvl || st_ff.mode != lfd_pkg::LFD_AUTO_FADE) begin
      nxt_st.deb_cnt = '0;
    end else if (deb_evt) begin
      nxt_st.deb_cnt = '0;
      nxt_st.deb_lvl = dim_s;
    end else begin
      nxt_st.deb_cnt = st_ff.deb_cnt + DEB_W'(1);
    end
    case (st_ff.mode)
      lfd_pkg::LFD_DIRECT: begin
        // immediate on/off, no ramp
        nxt_st.deb_lvl = dim_s;
        nxt_st.lit = act_now;
        nxt_st.level = act_now ? lfd_pkg::LVL_MAX : 6'h00;
        if (act_now != st_ff.lit) begin
          nxt_st.owner = 1'b1;
        end
        nxt_st.acc = '0;
        nxt_st.fast_cnt = '0;
      end
      lfd_pkg::LFD_AUTO_FADE: begin
        if (deb_evt) begin
          // latch follows debounced active level; reversal keeps current level
          nxt_st.lit = (dim_s ~^ st_ff.pol_sy[1]);
          nxt_st.owner = 1'b1;
        end
        if (!ramping) begin
          nxt_st.acc = '0;
          nxt_st.fast_cnt = '0;
        end else if (set_val == 20'h00000) begin
          // cancelled fade: fixed short step
          if (st_ff.fast_cnt == 6'(lfd_pkg::FAST_STEP_CYC - 1)) begin
            nxt_st.fast_cnt = '0;
            step = 1'b1;
          end else begin
            nxt_st.fast_cnt = st_ff.fast_cnt + 6'h01;
          end
        end else if (acc_sum >= ramp_thr) begin
          nxt_st.acc = acc_sum - ramp_thr;
          step = 1'b1;
        end else begin
          nxt_st.acc = acc_sum;
        end
        if (step) begin
          nxt_st.level = st_ff.lit ? st_ff.level + 6'h01 : st_ff.level - 6'h01;
        end
      end
      default: begin
        nxt_st.lit = 1'b0;
      end
    endcase
    // 220 hz carrier, 1000 slots
    if (st_ff.pwm_pre == 8'(lfd_pkg::PWM_STEP_CYC - 1)) begin
      nxt_st.pwm_pre = '0;
      nxt_st.pwm_cnt = (st_ff.pwm_cnt == 10'(lfd_pkg::DUTY_SCALE - 1)) ? 10'h000 : st_ff.pwm_cnt + 10'h001;
    end else begin
      nxt_st.pwm_pre = st_ff.pwm_pre + 8'h01;
    end
    // undervoltage lockout with hysteresis
    if (st_ff.uvl_sy[1]) begin
      nxt_st.uv_off = 1'b1;
    end else if (st_ff.uvh_sy[1]) begin
      nxt_st.uv_off = 1'b0;
    end
    // output drive
    if (st_ff.uv_off) begin
      nxt_st.out = 2'b00;
    end else if (!st_ff.owner) begin
      nxt_st.out = st_ff.sw_s;
    end else if (st_ff.mode == lfd_pkg::LFD_DIRECT) begin
      nxt_st.out = {2{act_now}};
    end else begin
      nxt_st.out = {2{st_ff.pwm_cnt < lfd_pkg::GAMMA[st_ff.level]}};
    end
    // apb slave: answer registered in the setup cycle
    nxt_st.rsp.pready = apb_i.psel && !apb_i.penable;
    if (apb_i.psel && !apb_i.penable) begin
      nxt_st.rsp.pslverr = 1'b0;
      nxt_st.rsp.prdata = 32'h00000000;
      case (apb_i.paddr)
        lfd_pkg::ADDR_FADE_IN: nxt_st.rsp.prdata = {12'h000, st_ff.fade_in};
        lfd_pkg::ADDR_FADE_OUT: nxt_st.rsp.prdata = {12'h000, st_ff.fade_out};
        lfd_pkg::ADDR_STATUS: begin
          nxt_st.rsp.prdata = {16'h0000, st_ff.out, st_ff.uv_off, st_ff.owner, st_ff.pol_sy[1],
                               st_ff.mode == lfd_pkg::LFD_DIRECT, st_ff.deb_lvl, st_ff.lit, 2'b00, st_ff.level};
          nxt_st.rsp.pslverr = apb_i.pwrite;
        end
        default: nxt_st.rsp.pslverr = 1'b1;
      endcase
    end
    if (wr) begin
      case (apb_i.paddr)
        lfd_pkg::ADDR_FADE_IN: nxt_st.fade_in = apb_i.pwdata[19:0];
        lfd_pkg::ADDR_FADE_OUT: nxt_st.fade_out = apb_i.pwdata[19:0];
        default: nxt_st.fade_in = st_ff.fade_in;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_ff <= '0;
      st_ff.fade_in <= lfd_pkg::FADE_IN_RST;
      st_ff.fade_out <= lfd_pkg::FADE_OUT_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign apb_o = st_ff.rsp;
  assign main_led_outputs_o = st_ff.out;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  chk_channels_joined: assert property (st_ff.owner && !$past(st_ff.uv_off) |=> main_led_outputs_o[0] == main_led_outputs_o[1])
    else $error("main channels differ under shared control");
  chk_uv_blanks: assert property (st_ff.uv_off |=> main_led_outputs_o == 2'b00)
    else $error("output on during undervoltage");
  chk_pol_high: assert property (st_ff.mode == lfd_pkg::LFD_DIRECT && st_ff.owner && !st_ff.uv_off && st_ff.pol_sy[1]
                                 && dim_s |=> main_led_outputs_o == 2'b11)
    else $error("active high dimming did not enable outputs");
  chk_pol_low: assert property (st_ff.mode == lfd_pkg::LFD_DIRECT && st_ff.owner && !st_ff.uv_off && !st_ff.pol_sy[1]
                                && dim_s |=> main_led_outputs_o == 2'b00)
    else $error("active low dimming did not disable outputs");
  chk_debounce_wait: assert property (st_ff.mode == lfd_pkg::LFD_AUTO_FADE && $past(st_ff.mode) == lfd_pkg::LFD_AUTO_FADE
                                      && $changed(st_ff.deb_lvl)
                                      |-> $past(st_ff.deb_cnt) == DEB_W'(DEB_CYC - 1))
    else $error("debounced level changed early");
  chk_fast_fade: assert property (st_ff.mode == lfd_pkg::LFD_AUTO_FADE && st_ff.lit && st_ff.fade_in == 20'h00000
                                  && st_ff.level != lfd_pkg::LVL_MAX |-> ##[1:60] st_ff.level != $past(st_ff.level))
    else $error("cancelled fade did not step in time");
  chk_level_range: assert property (st_ff.level <= lfd_pkg::LVL_MAX)
    else $error("gamma index out of range");
  chk_ramp_down: assert property (st_ff.mode == lfd_pkg::LFD_AUTO_FADE && !st_ff.lit && !deb_evt
                                  |=> st_ff.level <= $past(st_ff.level))
    else $error("level rose while unlit");
  chk_pwm_span: assert property (st_ff.pwm_cnt < 10'(lfd_pkg::DUTY_SCALE))
    else $error("pwm slot counter out of range");
endmodule
`default_nettype wire

// >>> tb/lfd_dim_src.sv
// lfd_dim_src: external dimming source driving the shared dimming pin
// assumes the bench selects steady level or a free running pwm
`timescale 1ns/1ps
`default_nettype none
module lfd_dim_src (
  input wire logic clk_i,
  input wire logic pwm_on_i,
  input wire logic level_i,
  input wire logic [7:0] period_i,
  input wire logic [7:0] high_i,
  output logic dim_o
);
  logic [7:0] cnt_ff;
  always_ff @(posedge clk_i) begin
    if (!pwm_on_i || cnt_ff == period_i - 8'h01) begin
      cnt_ff <= 8'h00;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end
  // pin is always driven: steady level or pwm pattern
  assign dim_o = pwm_on_i ? (cnt_ff < high_i) : level_i;
endmodule
`default_nettype wire

// >>> tb/lfd_top_tb_top.sv
// lfd_top_tb_top: apb and pin level tests of the led fade dimming controller
// assumes a 20 cycle debounce and small fade settings
`timescale 1ns/1ps
`default_nettype none
module lfd_top_tb_top;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  lfd_pkg::lfd_apb_req_t req = '0;
  lfd_pkg::lfd_apb_rsp_t rsp;
  logic src_pwm = 1'b0;
  logic src_lvl = 1'b0;
  logic dim;
  logic mode = 1'b0;
  logic polarity_select = 1'b1;
  logic [1:0] sw = 2'h0;
  logic uv_lo = 1'b0;
  logic uv_hi = 1'b1;
  logic [1:0] out;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  initial forever #10 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;
  lfd_top #(.DEB_CYC(20)) i_dut (.clk_i(clk_i), .reset_i(reset_i), .apb_i(req), .apb_o(rsp), .dim_i(dim),
    .dimming_source_select_i(mode), .polarity_select_i(polarity_select), .channel_switch_inputs_i(sw),
    .uv_below_4v5_i(uv_lo), .uv_above_4v6_i(uv_hi), .main_led_outputs_o(out));
  lfd_dim_src i_src (.clk_i(clk_i), .pwm_on_i(src_pwm), .level_i(src_lvl), .period_i(8'h10),
    .high_i(8'h08), .dim_o(dim));
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_out(input string what, input logic [1:0] exp);
    checks++;
    if (out !== exp) begin
      miscompares++;
      $display("Error %s expected %b seen %b", what, exp, out);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk_i);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  task automatic wait_lvl(input logic [5:0] lvl, output logic [5:0] top);
    top = 6'h00;
    do begin
      apb(1'b0, lfd_pkg::ADDR_STATUS, 32'h0);
      if (rd[5:0] > top) top = rd[5:0];
    end while (rd[5:0] !== lvl);
  endtask
  task automatic finish_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    finish_test();
  end
  initial begin
    logic [5:0] top;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    apb(1'b0, lfd_pkg::ADDR_FADE_OUT, 32'h0);
    chk_word("fade_out reset", 32'h0001E848, rd);
    apb(1'b0, 8'h0C, 32'h0);
    chk_word("unmapped err", 32'h1, {31'h0, err});
    apb(1'b1, lfd_pkg::ADDR_STATUS, 32'hFFFF);
    chk_word("status write err", 32'h1, {31'h0, err});
    sw <= 2'h1;
    repeat (6) @(posedge clk_i);
    chk_out("switch", 2'h1);
    $display("test reset done");
    apb(1'b1, lfd_pkg::ADDR_FADE_IN, 32'h1E);
    apb(1'b1, lfd_pkg::ADDR_FADE_OUT, 32'h0);
    apb(1'b0, lfd_pkg::ADDR_FADE_IN, 32'h0);
    chk_word("fade_in rw", 32'h1E, rd);
    src_lvl <= 1'b1;
    repeat (10) @(posedge clk_i);
    src_lvl <= 1'b0;
    repeat (40) @(posedge clk_i);
    apb(1'b0, lfd_pkg::ADDR_STATUS, 32'h0);
    chk_word("glitch lit", 32'h0, {31'h0, rd[8]});
    src_lvl <= 1'b1;
    n = cyc;
    wait_lvl(6'h14, top);
    chk_word("ramp pace", 32'h1, {31'h0, (cyc - n) > 1150 && (cyc - n) < 1330});
    src_lvl <= 1'b0;
    wait_lvl(6'h00, top);
    chk_word("reversal top", 32'h1, {31'h0, top < 6'h18});
    apb(1'b1, lfd_pkg::ADDR_FADE_IN, 32'h2);
    src_lvl <= 1'b1;
    wait_lvl(6'h3E, top);
    chk_word("lit", 32'h1, {31'h0, rd[8]});
    chk_out("full both", 2'h3);
    src_lvl <= 1'b0;
    n = cyc;
    wait_lvl(6'h00, top);
    chk_word("fast fade", 32'h1, {31'h0, (cyc - n) < 3600 && rd[8] === 1'b0});
    $display("test auto done");
    mode <= 1'b1;
    polarity_select <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk_out("direct on", 2'h3);
    src_lvl <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk_out("direct off", 2'h0);
    src_pwm <= 1'b1;
    repeat (20) @(posedge clk_i);
    n = 0;
    repeat (160) begin
      @(posedge clk_i);
      if (out === 2'h3) n++;
    end
    chk_word("direct duty", 32'd80, n);
    src_pwm <= 1'b0;
    $display("test direct done");
    mode <= 1'b0;
    polarity_select <= 1'b1;
    src_lvl <= 1'b0;
    apb(1'b1, lfd_pkg::ADDR_FADE_IN, 32'h0);
    repeat (30) @(posedge clk_i);
    src_lvl <= 1'b1;
    wait_lvl(6'h3E, top);
    uv_lo <= 1'b1;
    uv_hi <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk_out("uv off", 2'h0);
    apb(1'b0, lfd_pkg::ADDR_STATUS, 32'h0);
    chk_word("uv latch", 32'h1, {31'h0, rd[8]});
    uv_lo <= 1'b0;
    uv_hi <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk_out("uv back", 2'h3);
    polarity_select <= 1'b0;
    src_lvl <= 1'b0;
    repeat (40) @(posedge clk_i);
    apb(1'b0, lfd_pkg::ADDR_STATUS, 32'h0);
    chk_word("low fall keeps lit", 32'h1, {31'h0, rd[8]});
    src_lvl <= 1'b1;
    wait_lvl(6'h00, top);
    chk_word("low rise fades out", 32'h0, {31'h0, rd[8]});
    reset_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    apb(1'b0, lfd_pkg::ADDR_STATUS, 32'h0);
    chk_word("latch reset", 32'h0, {31'h0, rd[8]});
    $display("test uv done");
    finish_test();
  end
endmodule
`default_nettype wire
